// file: alarm_pkg.sv
package alarm_pkg;

	// ********************************
	// Register byte offsets
	// ********************************
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_MASK = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_LANE = 8'h0C;
	localparam logic [7:0] OFS_SUMMARY = 8'h10;

	// ********************************
	// Sizes
	// ********************************
	localparam int NUM_ALARMS = 6;
	localparam int NUM_LANES = 8;

	// ********************************
	// Alarm bit positions in the status and mask words
	// ********************************
	localparam int ALM_CPLL = 0;
	localparam int ALM_SPLL = 1;
	localparam int ALM_LINK = 2;
	localparam int ALM_SYSREF = 3;
	localparam int ALM_CLK = 4;
	localparam int ALM_FIFO = 5;

	// ********************************
	// Control word bit positions and width
	// ********************************
	localparam int CTL_LINK_EN = 0;
	localparam int CTL_CAL_SEL = 1;
	localparam int CTL_PD_A = 2;
	localparam int CTL_PD_B = 3;
	localparam int CTL_GPD = 4;
	localparam int CTL_WIDTH = 5;

	// ********************************
	// Reset values
	// ********************************
	localparam logic [NUM_ALARMS-1:0] RST_STATUS = 6'h00;
	localparam logic [NUM_ALARMS-1:0] RST_MASK = 6'h3F;
	localparam logic [CTL_WIDTH-1:0] RST_CTRL = 5'h00;
	localparam logic [NUM_LANES-1:0] RST_LANE = 8'h00;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage : alarm_pkg

// file: clk_upset_cmp.sv
`timescale 1ns/1ps

// Compares the channel A and B half-rate clock phases every cycle that enable is high
module clk_upset_cmp (
	input wire logic sys_clk, // 200 MHz clock
	input wire logic srst, // Synchronous reset, high
	input wire logic enable, // Comparison is meaningful
	input wire logic phase_a, // Channel A half-rate phase
	input wire logic phase_b, // Channel B half-rate phase
	output logic upset // One-cycle mismatch pulse
);
	logic upset_d;

	// Any single differing cycle counts; no filtering on purpose
	always_comb begin
		upset_d = enable && (phase_a != phase_b);
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			upset <= 1'b0;
		end else begin
			upset <= upset_d;
		end
	end

	// ********************************
	// Checks
	// ********************************
	AST_MISMATCH_FLAGS: assert property (
		@(posedge sys_clk) disable iff (srst)
		enable && (phase_a != phase_b) |=> upset)
		else $error("Clock mismatch not flagged");
	AST_NO_FALSE_UPSET: assert property (
		@(posedge sys_clk) disable iff (srst)
		!enable |=> !upset)
		else $error("Upset raised while comparison disabled");

endmodule : clk_upset_cmp

// file: alarm_monitor_unit.sv
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Contract
// - Six separate sticky alarm flags: two PLL unlocks, link not in data, SYSREF realign, clock upset, FIFO error.
// - An alarm flag stays set until the host writes 1 to its position.
// - A set alarm reaches the summary indication only when its mask bit is clear.
// - With alarm output selected, the calibration status pin goes high when an unmasked alarm is present.
// - Channel A and B clocks are compared while the link is enabled, both channels are up and power-down is off; a single differing cycle sets the clock upset flag.
// - The clock upset flag stays set until the host writes 1 to it.
// - Leaving global power-down by register or pin may set the clock upset flag, which the host then clears.
// - One FIFO error flag per lane, set when that lane's FIFO pointers are upset.
// - Taking link enable to 0 and back to 1 resets the synchronizing FIFO logic.
// - While link enable is 0 the link is held in reset, serializers powered down and its clocks gated.
module alarm_monitor_unit
	import alarm_pkg::*;
(
	input wire logic sys_clk, // 200 MHz clock
	input wire logic srst, // Synchronous reset, high
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction, high writes
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic cpll_locked, // Clock PLL lock
	input wire logic spll_locked, // Serializer PLL lock
	input wire logic link_in_data, // Link in data transmission state
	input wire logic sysref_realign, // SYSREF realigned clocks, pulse
	input wire logic chan_a_phase, // Channel A half-rate clock phase
	input wire logic chan_b_phase, // Channel B half-rate clock phase
	input wire logic [NUM_LANES-1:0] lane_ptr_err, // Per-lane FIFO pointer error
	input wire logic powerdown_pin, // Global power-down pin, high
	input wire logic cal_status_in, // Calibration status when not alarm
	output logic cal_status_output_pin, // Calibration status / alarm pin
	output logic alarm_summary, // Unmasked alarm present
	output logic link_reset, // Link block held in reset
	output logic serializer_pd, // Serializers powered down
	output logic link_clk_en, // Link clock gate enable
	output logic fifo_reset // Synchronizing FIFO reset
);

	// ********************************
	// State
	// ********************************
	logic [NUM_ALARMS-1:0] alarm_status_flags_q, alarm_status_flags_d;
	logic [NUM_ALARMS-1:0] alarm_mask_bits_q, alarm_mask_bits_d;
	logic [CTL_WIDTH-1:0] ctrl_q, ctrl_d;
	logic [NUM_LANES-1:0] lane_fifo_error_flags_q, lane_fifo_error_flags_d;
	logic pd_active_q, pd_active_d;
	logic [31:0] prdata_d;
	logic pready_d, pslverr_d;
	logic cal_pin_d, summary_d;
	logic link_reset_d, ser_pd_d, clk_en_d, fifo_reset_d;
	logic wr_fire, setup_phase, pd_now, pd_exit, clk_upset, cmp_enable;
	logic link_enable;
	logic [NUM_ALARMS-1:0] alarm_events, status_w1c;
	logic [NUM_LANES-1:0] lane_w1c;
	logic [31:0] status_w1c_word, lane_w1c_word;

	// Known register offset check, used by the error path only
	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == OFS_STATUS) || (a == OFS_MASK) ||
			(a == OFS_CTRL) || (a == OFS_LANE) || (a == OFS_SUMMARY);
	endfunction : addr_mapped

	// Write-one-to-clear mask for a register, zero unless addressed
	// Bus bits come in as arguments so every caller sees their changes
	function automatic logic [31:0] w1c_bits(input logic [7:0] ofs,
		input logic fire, input logic [7:0] a, input logic [31:0] d);
		w1c_bits = (fire && a == ofs) ? d : ZERO_WORD;
	endfunction : w1c_bits

	// ********************************
	// Bus strobes
	// ********************************
	// Writes commit only at the edge that completes the access phase
	assign setup_phase = psel && !penable;
	assign wr_fire = psel && penable && pready && pwrite;
	assign link_enable = ctrl_q[CTL_LINK_EN];
	assign pd_now = ctrl_q[CTL_GPD] || powerdown_pin;
	assign pd_exit = pd_active_q && !pd_now;
	// Full words first, then cut to the flag widths on purpose
	assign status_w1c_word = w1c_bits(OFS_STATUS, wr_fire, paddr,
		pwdata);
	assign lane_w1c_word = w1c_bits(OFS_LANE, wr_fire, paddr, pwdata);
	assign status_w1c = status_w1c_word[NUM_ALARMS-1:0];
	assign lane_w1c = lane_w1c_word[NUM_LANES-1:0];

	// Comparison needs both channels up, the link running, no power-down
	assign cmp_enable = link_enable && !ctrl_q[CTL_PD_A] &&
		!ctrl_q[CTL_PD_B] && !pd_now;

	clk_upset_cmp u_cmp (
		.sys_clk(sys_clk),
		.srst(srst),
		.enable(cmp_enable),
		.phase_a(chan_a_phase),
		.phase_b(chan_b_phase),
		.upset(clk_upset)
	);

	// ********************************
	// Alarm sources
	// ********************************
	// Link state is only judged while the link is enabled
	always_comb begin
		alarm_events = '0;
		alarm_events[ALM_CPLL] = !cpll_locked;
		alarm_events[ALM_SPLL] = !spll_locked;
		alarm_events[ALM_LINK] = link_enable && !link_in_data;
		alarm_events[ALM_SYSREF] = sysref_realign;
		// Power-down exit leaves the clock trees unrelated
		alarm_events[ALM_CLK] = clk_upset || pd_exit;
		alarm_events[ALM_FIFO] = link_enable && (|lane_ptr_err);
	end

	// ********************************
	// Register next values
	// ********************************
	// Set wins over clear so no event is lost in a clearing write
	always_comb begin
		alarm_status_flags_d = (alarm_status_flags_q & ~status_w1c)
			| alarm_events;
		lane_fifo_error_flags_d = (lane_fifo_error_flags_q & ~lane_w1c)
			| (lane_ptr_err & {NUM_LANES{link_enable}});
		alarm_mask_bits_d = alarm_mask_bits_q;
		ctrl_d = ctrl_q;
		if (wr_fire && paddr == OFS_MASK) begin
			alarm_mask_bits_d = pwdata[NUM_ALARMS-1:0];
		end
		if (wr_fire && paddr == OFS_CTRL) begin
			ctrl_d = pwdata[CTL_WIDTH-1:0];
		end
		pd_active_d = pd_now;
	end

	// ********************************
	// Bus answer
	// ********************************
	// Ready one cycle after setup: every access has one wait-free phase
	always_comb begin
		pready_d = setup_phase;
		pslverr_d = setup_phase && !addr_mapped(paddr);
		prdata_d = ZERO_WORD;
		if (setup_phase && !pwrite) begin
			case (paddr)
				OFS_STATUS: begin
					prdata_d[NUM_ALARMS-1:0] = alarm_status_flags_q;
				end
				OFS_MASK: begin
					prdata_d[NUM_ALARMS-1:0] = alarm_mask_bits_q;
				end
				OFS_CTRL: begin
					prdata_d[CTL_WIDTH-1:0] = ctrl_q;
				end
				OFS_LANE: begin
					prdata_d[NUM_LANES-1:0] = lane_fifo_error_flags_q;
				end
				OFS_SUMMARY: begin
					prdata_d[0] = alarm_summary;
				end
				default: begin
					prdata_d = ZERO_WORD;
				end
			endcase
		end
	end

	// ********************************
	// Pin outputs
	// ********************************
	// Outputs lag the flags by one cycle so they leave flip-flops
	always_comb begin
		summary_d = |(alarm_status_flags_q & ~alarm_mask_bits_q);
		cal_pin_d = ctrl_q[CTL_CAL_SEL] ? summary_d
			: cal_status_in;
		link_reset_d = !link_enable;
		ser_pd_d = !link_enable;
		clk_en_d = link_enable;
		// FIFO held in reset while disabled, released on re-enable
		fifo_reset_d = !link_enable;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			alarm_status_flags_q <= RST_STATUS;
			alarm_mask_bits_q <= RST_MASK;
			ctrl_q <= RST_CTRL;
			lane_fifo_error_flags_q <= RST_LANE;
			pd_active_q <= 1'b0;
			prdata <= ZERO_WORD;
			pready <= 1'b0;
			pslverr <= 1'b0;
			alarm_summary <= 1'b0;
			cal_status_output_pin <= 1'b0;
			link_reset <= 1'b1;
			serializer_pd <= 1'b1;
			link_clk_en <= 1'b0;
			fifo_reset <= 1'b1;
		end else begin
			alarm_status_flags_q <= alarm_status_flags_d;
			alarm_mask_bits_q <= alarm_mask_bits_d;
			ctrl_q <= ctrl_d;
			lane_fifo_error_flags_q <= lane_fifo_error_flags_d;
			pd_active_q <= pd_active_d;
			prdata <= prdata_d;
			pready <= pready_d;
			pslverr <= pslverr_d;
			alarm_summary <= summary_d;
			cal_status_output_pin <= cal_pin_d;
			link_reset <= link_reset_d;
			serializer_pd <= ser_pd_d;
			link_clk_en <= clk_en_d;
			fifo_reset <= fifo_reset_d;
		end
	end

	// ********************************
	// Checks
	// ********************************
	sequence s_clk_clear;
		wr_fire && paddr == OFS_STATUS && pwdata[ALM_CLK]
			&& !alarm_events[ALM_CLK];
	endsequence

	sequence s_link_toggle;
		!link_enable ##1 link_enable;
	endsequence

	AST_CPLL_STICKY: assert property (
		@(posedge sys_clk) disable iff (srst)
		!cpll_locked |=> alarm_status_flags_q[ALM_CPLL])
		else $error("PLL unlock not recorded");
	AST_SPLL_STICKY: assert property (
		@(posedge sys_clk) disable iff (srst)
		!spll_locked |=> alarm_status_flags_q[ALM_SPLL])
		else $error("Serializer PLL unlock not recorded");
	AST_LINK_ALARM: assert property (
		@(posedge sys_clk) disable iff (srst)
		link_enable && !link_in_data |=> alarm_status_flags_q[ALM_LINK])
		else $error("Link out of data state not recorded");
	AST_FLAG_HOLDS: assert property (
		@(posedge sys_clk) disable iff (srst)
		alarm_status_flags_q[ALM_SYSREF] && !status_w1c[ALM_SYSREF]
		|=> alarm_status_flags_q[ALM_SYSREF])
		else $error("Flag dropped without clear");
	AST_CLK_HOLDS: assert property (
		@(posedge sys_clk) disable iff (srst)
		alarm_status_flags_q[ALM_CLK] && !status_w1c[ALM_CLK]
		|=> alarm_status_flags_q[ALM_CLK])
		else $error("Clock upset flag dropped without clear");
	AST_CLK_CLEARS: assert property (
		@(posedge sys_clk) disable iff (srst)
		s_clk_clear |=> !alarm_status_flags_q[ALM_CLK])
		else $error("Clock upset flag not cleared");
	AST_SET_WINS: assert property (
		@(posedge sys_clk) disable iff (srst)
		sysref_realign && status_w1c[ALM_SYSREF]
		|=> alarm_status_flags_q[ALM_SYSREF])
		else $error("Clear beat a new event");
	AST_WRITE_ZERO: assert property (
		@(posedge sys_clk) disable iff (srst)
		alarm_status_flags_q[ALM_CPLL] && wr_fire && paddr == OFS_STATUS
		&& !pwdata[ALM_CPLL] |=> alarm_status_flags_q[ALM_CPLL])
		else $error("Zero write cleared a flag");
	AST_SUMMARY: assert property (
		@(posedge sys_clk) disable iff (srst)
		##1 alarm_summary ==
		$past(|(alarm_status_flags_q & ~alarm_mask_bits_q)))
		else $error("Summary does not follow unmasked flags");
	AST_MASKED_QUIET: assert property (
		@(posedge sys_clk) disable iff (srst)
		&alarm_mask_bits_q |=> !alarm_summary)
		else $error("Summary raised with every alarm masked");
	AST_CAL_PIN: assert property (
		@(posedge sys_clk) disable iff (srst)
		ctrl_q[CTL_CAL_SEL] && summary_d |=> cal_status_output_pin)
		else $error("Alarm pin not raised");
	AST_CAL_FOLLOWS: assert property (
		@(posedge sys_clk) disable iff (srst)
		!ctrl_q[CTL_CAL_SEL]
		|=> cal_status_output_pin == $past(cal_status_in))
		else $error("Pin does not follow calibration status");
	AST_PD_EXIT: assert property (
		@(posedge sys_clk) disable iff (srst)
		pd_exit |=> alarm_status_flags_q[ALM_CLK])
		else $error("Power-down exit did not flag clocks");
	AST_LANE_SET: assert property (
		@(posedge sys_clk) disable iff (srst)
		link_enable && lane_ptr_err[0] |=> lane_fifo_error_flags_q[0]
		&& alarm_status_flags_q[ALM_FIFO])
		else $error("Lane FIFO error not recorded");
	AST_LANE_HOLDS: assert property (
		@(posedge sys_clk) disable iff (srst)
		lane_fifo_error_flags_q[7] && !lane_w1c[7]
		|=> lane_fifo_error_flags_q[7])
		else $error("Lane flag dropped without clear");
	AST_FIFO_RELEASE: assert property (
		@(posedge sys_clk) disable iff (srst)
		s_link_toggle |-> fifo_reset ##1 !fifo_reset)
		else $error("FIFO reset not released after toggle");
	AST_LINK_OFF: assert property (
		@(posedge sys_clk) disable iff (srst)
		!link_enable ##1 !link_enable |-> link_reset && serializer_pd
		&& !link_clk_en)
		else $error("Link not held off while disabled");
	AST_LANE_GATED: assert property (
		@(posedge sys_clk) disable iff (srst)
		!link_enable && !lane_fifo_error_flags_q[0]
		|=> !lane_fifo_error_flags_q[0])
		else $error("Lane flag set while link held in reset");

endmodule : alarm_monitor_unit

// file: tb.sv
`timescale 1ns/1ps
module tb;
	import alarm_pkg::*;
	typedef struct packed {
		logic wr;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] x;
		logic err;
	} row_t;
	logic sys_clk, srst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic cpll_locked, spll_locked, link_in_data, sysref_realign;
	logic chan_a_phase, chan_b_phase, powerdown_pin, cal_status_in;
	logic [NUM_LANES-1:0] lane_ptr_err;
	logic cal_status_output_pin, alarm_summary, link_reset;
	logic serializer_pd, link_clk_en, fifo_reset;
	int errors = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [31:0] prd;
	logic perr;
	// Control words for the comparison check, and the flag each leaves
	logic [31:0] pdv [3] = '{32'h0000_0003, 32'h0000_0007, 32'h0000_000B};
	logic [31:0] pdx [3] = '{32'h0000_0010, ZERO_WORD, ZERO_WORD};
	// Register map walk; also leaves link on, mask open, alarm pin chosen
	row_t rows [13] = '{
		'{1'b0, OFS_STATUS, ZERO_WORD, ZERO_WORD, 1'b0},
		'{1'b0, OFS_MASK, ZERO_WORD, 32'h0000_003F, 1'b0},
		'{1'b0, OFS_CTRL, ZERO_WORD, ZERO_WORD, 1'b0},
		'{1'b0, OFS_LANE, ZERO_WORD, ZERO_WORD, 1'b0},
		'{1'b0, OFS_SUMMARY, ZERO_WORD, ZERO_WORD, 1'b0},
		'{1'b0, 8'h14, ZERO_WORD, ZERO_WORD, 1'b1},
		'{1'b1, 8'h14, 32'hFFFF_FFFF, ZERO_WORD, 1'b1},
		'{1'b1, OFS_SUMMARY, 32'h0000_0001, ZERO_WORD, 1'b0},
		'{1'b0, OFS_SUMMARY, ZERO_WORD, ZERO_WORD, 1'b0},
		'{1'b1, OFS_MASK, 32'hFFFF_FFC0, ZERO_WORD, 1'b0},
		'{1'b0, OFS_MASK, ZERO_WORD, ZERO_WORD, 1'b0},
		'{1'b1, OFS_CTRL, 32'h0000_0003, ZERO_WORD, 1'b0},
		'{1'b0, OFS_CTRL, ZERO_WORD, 32'h0000_0003, 1'b0}
	};

	alarm_monitor_unit i_alarm_monitor_unit (
		.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cpll_locked(cpll_locked),
		.spll_locked(spll_locked), .link_in_data(link_in_data),
		.sysref_realign(sysref_realign), .chan_a_phase(chan_a_phase),
		.chan_b_phase(chan_b_phase), .lane_ptr_err(lane_ptr_err),
		.powerdown_pin(powerdown_pin), .cal_status_in(cal_status_in),
		.cal_status_output_pin(cal_status_output_pin),
		.alarm_summary(alarm_summary), .link_reset(link_reset),
		.serializer_pd(serializer_pd), .link_clk_en(link_clk_en),
		.fifo_reset(fifo_reset)
	);

	// ****************
	// Clock, timeout, helpers
	// ****************
	initial begin
		sys_clk = 0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// Cuts a hang short; the whole run needs well under a thousand cycles
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			tally_and_finish;
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge sys_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, ZERO_WORD, r, e);
		chk(r, x);
	endtask : rd

	// Healthy sources: locked, in data, clocks matched
	task quiet;
		cpll_locked <= 1;
		spll_locked <= 1;
		link_in_data <= 1;
		sysref_realign <= 0;
		chan_b_phase <= 0;
		lane_ptr_err <= '0;
	endtask : quiet

	function automatic logic [31:0] pins;
		return 32'({link_reset, serializer_pd, link_clk_en, fifo_reset});
	endfunction : pins

	task tally_and_finish;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	// ****************
	// Main sequence
	// ****************
	initial begin
		{srst, cpll_locked, spll_locked, link_in_data} = 4'hF;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{sysref_realign, chan_a_phase, chan_b_phase} = '0;
		{powerdown_pin, cal_status_in, lane_ptr_err} = '0;
		repeat (12) @(posedge sys_clk);
		srst <= 0;
		// Second edge, so the pins seen were launched by the first
		repeat (2) @(posedge sys_clk);
		chk(pins(), 32'h0000_000D);
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].d, prd, perr);
			if (!rows[i].wr) chk(prd, rows[i].x);
			chk(32'(perr), 32'(rows[i].err));
		end
		chk(pins(), 32'h0000_0002);
		// Each single-cycle source but the FIFO one must stick, report and clear alone
		for (int i = 0; i < 5; i++) begin
			@(posedge sys_clk);
			case (i)
				0: cpll_locked <= 0;
				1: spll_locked <= 0;
				2: link_in_data <= 0;
				3: sysref_realign <= 1;
				default: chan_b_phase <= 1;
			endcase
			@(posedge sys_clk);
			quiet();
			repeat (5) @(posedge sys_clk);
			chk(32'(alarm_summary), 32'h0000_0001);
			chk(32'(cal_status_output_pin), 32'h0000_0001);
			rd(OFS_STATUS, 32'(1 << i));
			wr(OFS_STATUS, ZERO_WORD);
			rd(OFS_STATUS, 32'(1 << i));
			wr(OFS_STATUS, 32'(1 << i));
			rd(OFS_STATUS, ZERO_WORD);
		end
		// Masked alarm stays out of the summary; held source beats a clear
		wr(OFS_MASK, 32'h0000_0008);
		sysref_realign <= 1;
		wr(OFS_STATUS, 32'h0000_0008);
		rd(OFS_STATUS, 32'h0000_0008);
		chk(32'(alarm_summary), ZERO_WORD);
		rd(OFS_SUMMARY, ZERO_WORD);
		sysref_realign <= 0;
		wr(OFS_STATUS, 32'h0000_0008);
		wr(OFS_MASK, ZERO_WORD);
		// Per-lane FIFO flags
		@(posedge sys_clk);
		lane_ptr_err <= 8'h81;
		@(posedge sys_clk);
		lane_ptr_err <= 8'h00;
		rd(OFS_LANE, 32'h0000_0081);
		rd(OFS_STATUS, 32'h0000_0020);
		wr(OFS_LANE, 32'h0000_0001);
		rd(OFS_LANE, 32'h0000_0080);
		wr(OFS_LANE, 32'h0000_0080);
		wr(OFS_STATUS, 32'h0000_0020);
		// Leaving global power-down by register, then by pin
		wr(OFS_CTRL, 32'h0000_0013);
		wr(OFS_CTRL, 32'h0000_0003);
		rd(OFS_STATUS, 32'h0000_0010);
		wr(OFS_STATUS, 32'h0000_0010);
		powerdown_pin <= 1;
		repeat (2) @(posedge sys_clk);
		powerdown_pin <= 0;
		repeat (3) @(posedge sys_clk);
		rd(OFS_STATUS, 32'h0000_0010);
		wr(OFS_STATUS, 32'h0000_0010);
		rd(OFS_STATUS, ZERO_WORD);
		// Link off holds the FIFO in reset, so lane errors are ignored
		wr(OFS_CTRL, 32'h0000_0002);
		lane_ptr_err <= 8'hFF;
		repeat (3) @(posedge sys_clk);
		lane_ptr_err <= 8'h00;
		chk(pins(), 32'h0000_000D);
		rd(OFS_LANE, ZERO_WORD);
		wr(OFS_CTRL, 32'h0000_0003);
		repeat (2) @(posedge sys_clk);
		chk(pins(), 32'h0000_0002);
		// Link cycled with both channels up: clear, then watch the flag
		wr(OFS_STATUS, 32'h0000_0010);
		rd(OFS_STATUS, ZERO_WORD);
		// One-cycle mismatch counts only with both channels powered
		foreach (pdv[k]) begin
			wr(OFS_CTRL, pdv[k]);
			@(posedge sys_clk);
			chan_a_phase <= 1;
			@(posedge sys_clk);
			chan_a_phase <= 0;
			repeat (2) @(posedge sys_clk);
			rd(OFS_STATUS, pdx[k]);
			wr(OFS_STATUS, 32'h0000_0010);
		end
		wr(OFS_CTRL, 32'h0000_0003);
		// Mid-run reset; pin then follows the calibration status input
		srst <= 1;
		cal_status_in <= 1;
		repeat (2) @(posedge sys_clk);
		srst <= 0;
		repeat (3) @(posedge sys_clk);
		chk(pins(), 32'h0000_000D);
		chk(32'(cal_status_output_pin), 32'h0000_0001);
		rd(OFS_MASK, 32'h0000_003F);
		tally_and_finish;
	end
endmodule : tb
